// >>> design/t1e1_tx_cfg_map.svh
// Register map constants of the per-port transmit configuration bank.
// Assumes byte addresses on the bus are four times the register index.
`ifndef T1E1_TX_CFG_MAP_SVH
`define T1E1_TX_CFG_MAP_SVH

// ----------------------------------------------------------------
// Register indexes and write masks
// ----------------------------------------------------------------
`define IDX_IO        10'h184
`define IDX_ESC       10'h185
`define IDX_TC4       10'h186
`define IDX_HFC       10'h187
`define IDX_IBO       10'h188
`define IDX_MON       10'h189
`define IDX_XPC       10'h18A
`define IDX_CRC       10'h18C
`define IDX_STAT      10'h18D
`define IDX_MONB      10'h18E
`define RST_VAL       8'h00
`define WM_ESC        8'hDF
`define WM_HFC        8'h03
`define WM_IBO        8'h18
`define WM_MON        8'h1F
`define WM_XPC        8'h07
`define WM_CRC        8'h01

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define B_LC_INV      7
`define B_FS_INV      6
`define B_SS_INV      5
`define B_CLK_RATE    4
`define B_SS_MF       3
`define B_FS_DIR      2
`define B_DW          1
`define B_FS_MF       0
`define B_FMT         7
`define B_GAP         6
`define B_ZONE        4
`define B_ALIGN       3
`define B_ESRST       2
`define B_MINDLY      1
`define B_ES_EN       0
`define B_LAW         7
`define B_JAM         4
`define B_RAI         3
`define B_AIS         2
`define B_IBO_SEL     4
`define B_IBO_EN      3
`define B_BERT_DIR    2
`define B_BERT_FUS    1
`define B_BERT_EN     0
`define B_CRC_RECALC  0

// ----------------------------------------------------------------
// Elastic store figures (bytes)
// ----------------------------------------------------------------
`define ZONE_WIDE     6'd9
`define ZONE_NARROW   6'd2
`define MIN_DEPTH     6'd4
`endif

// >>> design/t1e1_tx_cfg_pkg.sv
// Types shared by the transmit configuration bank.
// Assumes the map header supplies all numeric constants.
package t1e1_tx_cfg_pkg;

  typedef struct packed {
    logic [7:0] io;
    logic [7:0] esc;
    logic [7:0] tc4;
    logic [7:0] hfc;
    logic [7:0] ibo;
    logic [7:0] mon;
    logic [7:0] xpc;
    logic [7:0] crc;
    logic [5:0] wp;
    logic [5:0] rp;
    logic       slip;
    logic [2:0] sy_lc;
    logic [2:0] sy_fs;
    logic [2:0] sy_ss;
    logic       f_lc;
    logic       f_fs;
    logic       f_ss;
    logic       dw_hold;
    logic       fs_o;
    logic [7:0] mon_byte;
    logic       ack;
    logic [7:0] rdata;
    logic       chclk;
    logic       chvalid;
    logic       rx_ser;
  } state_s;

endpackage : t1e1_tx_cfg_pkg

// >>> design/t1e1_transmit_path_config.sv
// Transmit-side configuration bank of one framer port with its pin
// polarity, sync pin, elastic store pointer and channel monitor logic.
// Assumes an Avalon-MM master on clk_sys and datapath strobes on clk_sys.
`timescale 1ns/1ps
`include "t1e1_tx_cfg_map.svh"

// Notes on behaviour
// - E1 CRC-4: 0 normal, 1 path recalculation
// - Invert line clock, frame sync, system sync input
// - Clock rate bit: software sets per backplane rate
// - System sync pin: frame or multiframe mode
// - Frame sync pin direction and mode bits
// - T1 double-wide sync pulse; software keeps legal
// - Data format: 64k all bits, 56k seven
// - Gapped clock enable gaps channel clock output
// - Conversion slip at 9 or 2 bytes
// - Align on rising write if under half frame, or under 2 bytes at minimum delay
// - Store reset places read pointer, may slip
// - Store enable bypass; two frames or 32-bit depth
// - Milliwatt code law: u-law or A-law
// - Inversion field: none, framing, signaling, payload
// - Jammed bit 8 and T1 signaling bit 7
// - ESF remote alarm: normal or CI variant
// - T1 AIS: unframed ones or CI variant
// - Loop code length field: 5,6,7,16 bits
// - FIFO low watermark: 4,16,32,48 bytes
// - Interleave enable and channel/frame select
// - Five-bit monitor channel select, 0 is channel 1
// - BERT port sources transmit or receive path
module t1e1_transmit_path_config #(
  parameter int FRAME_BYTES = 32
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        t1_mode,
  input  wire logic        esf_mode,
  input  wire logic        conversion_mode,
  input  wire logic        signaling_frame,
  input  wire logic        tx_line_clock_in,
  output logic             tx_line_clock_level,
  input  wire logic        line_frame_sync_pin_i,
  output logic             line_frame_sync_pin_o,
  output logic             line_frame_sync_pin_oe,
  input  wire logic        frame_sync_pulse,
  output logic             line_frame_sync_level,
  input  wire logic        sys_side_sync_pin_i,
  output logic             sys_side_sync_pin_o,
  output logic             sys_side_sync_pin_oe,
  input  wire logic        sys_sync_drive,
  input  wire logic        sys_sync_src,
  output logic             sys_sync_level,
  output logic             sys_sync_multiframe,
  output logic             tx_sync_multiframe,
  output logic             sys_clock_rate_select,
  output logic             crc_recalc_mode,
  input  wire logic        chan_clk_in,
  input  wire logic [2:0]  chan_bit_index,
  output logic             channel_clock_out,
  output logic             channel_bit_valid,
  input  wire logic        store_wr_tick,
  input  wire logic        store_rd_tick,
  output logic             store_bypass,
  output logic [5:0]       store_wr_ptr,
  output logic [5:0]       store_rd_ptr,
  output logic             store_slip,
  output logic             milliwatt_law_select,
  output logic             invert_framing,
  output logic             invert_signaling,
  output logic             invert_payload,
  input  wire logic        jam_chan_selected,
  output logic             force_bit8,
  output logic             force_bit7,
  input  wire logic        rai_active,
  input  wire logic        ais_active,
  output logic             send_rai_normal,
  output logic             send_rai_ci,
  output logic             send_ais_ones,
  output logic             send_ais_ci,
  output logic [4:0]       loop_code_bits,
  output logic [5:0]       fifo_low_watermark,
  output logic             interleave_active,
  output logic             interleave_select,
  input  wire logic [4:0]  tx_chan_index,
  input  wire logic [7:0]  tx_chan_byte,
  output logic [4:0]       monitor_channel_select,
  input  wire logic        bert_data,
  input  wire logic        rx_serial_in,
  output logic             rx_serial_data,
  output logic             bert_to_tx,
  output logic             bert_port_enable,
  output logic             bert_unframed
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  t1e1_tx_cfg_pkg::state_s st_ff;
  t1e1_tx_cfg_pkg::state_s nxt_st;

  logic [9:0] idx;
  logic       req;
  logic       wr_ok;
  logic [7:0] wd;
  logic [7:0] rd_val;
  logic [5:0] mask;
  logic [5:0] shift;
  logic [5:0] half;
  logic [5:0] sep;
  logic [5:0] zone;
  logic [5:0] base;
  logic [5:0] rsep;
  logic       align_edge;
  logic       rst_edge;
  logic       fs_out_raw;

  assign idx   = avs_address[11:2];
  assign req   = avs_read | avs_write;
  assign wd    = avs_writedata[7:0];
  assign wr_ok = avs_write & st_ff.ack & avs_byteenable[0];

  // One wait cycle on every access; the answer is taken on the second edge
  assign avs_waitrequest = req & ~st_ff.ack;
  assign avs_readdata    = {24'h000000, st_ff.rdata};

  // ----------------------------------------------------------------
  // Elastic store geometry
  // ----------------------------------------------------------------
  always_comb begin
    mask  = st_ff.esc[`B_MINDLY] ? (`MIN_DEPTH - 6'd1)
                                 : 6'((2 * FRAME_BYTES) - 1);
    shift = st_ff.esc[`B_MINDLY] ? (`MIN_DEPTH >> 1) : 6'(FRAME_BYTES);
    half  = st_ff.esc[`B_MINDLY] ? (`MIN_DEPTH >> 1) : 6'(FRAME_BYTES / 2);
    zone  = st_ff.esc[`B_ZONE] ? `ZONE_NARROW : `ZONE_WIDE;
    sep   = (st_ff.wp - st_ff.rp) & mask;
    base  = st_ff.wp & ~(shift - 6'd1);
    rsep  = (st_ff.wp - base) & mask;
  end

  assign align_edge = wr_ok && idx == `IDX_ESC && wd[`B_ALIGN]
                      && !st_ff.esc[`B_ALIGN];
  assign rst_edge   = wr_ok && idx == `IDX_ESC && wd[`B_ESRST]
                      && !st_ff.esc[`B_ESRST];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (idx)
      `IDX_IO:   rd_val = st_ff.io;
      `IDX_ESC:  rd_val = st_ff.esc;
      `IDX_TC4:  rd_val = st_ff.tc4;
      `IDX_HFC:  rd_val = st_ff.hfc;
      `IDX_IBO:  rd_val = st_ff.ibo;
      `IDX_MON:  rd_val = st_ff.mon;
      `IDX_XPC:  rd_val = st_ff.xpc;
      `IDX_CRC:  rd_val = st_ff.crc;
      `IDX_STAT: rd_val = {1'b0, st_ff.slip, sep};
      `IDX_MONB: rd_val = st_ff.mon_byte;
      default:   rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = req & ~st_ff.ack;
    if (req && !st_ff.ack) begin
      nxt_st.rdata = rd_val;
    end

    // Writes land on the edge that ends the wait; unmapped ones vanish
    if (wr_ok) begin
      case (idx)
        `IDX_IO:  nxt_st.io  = wd;
        `IDX_ESC: nxt_st.esc = wd & `WM_ESC;
        `IDX_TC4: nxt_st.tc4 = wd;
        `IDX_HFC: nxt_st.hfc = wd & `WM_HFC;
        `IDX_IBO: nxt_st.ibo = wd & `WM_IBO;
        `IDX_MON: nxt_st.mon = wd & `WM_MON;
        `IDX_XPC: nxt_st.xpc = wd & `WM_XPC;
        `IDX_CRC: nxt_st.crc = wd & `WM_CRC;
        default:  nxt_st.crc = st_ff.crc;
      endcase
    end

    // Three-stage pin capture; a level counts once stages two and three agree
    nxt_st.sy_lc = {st_ff.sy_lc[1:0], tx_line_clock_in};
    nxt_st.sy_fs = {st_ff.sy_fs[1:0], line_frame_sync_pin_i};
    nxt_st.sy_ss = {st_ff.sy_ss[1:0], sys_side_sync_pin_i};
    if (st_ff.sy_lc[1] == st_ff.sy_lc[2]) begin
      nxt_st.f_lc = st_ff.sy_lc[2];
    end
    if (st_ff.sy_fs[1] == st_ff.sy_fs[2]) begin
      nxt_st.f_fs = st_ff.sy_fs[2];
    end
    if (st_ff.sy_ss[1] == st_ff.sy_ss[2]) begin
      nxt_st.f_ss = st_ff.sy_ss[2];
    end

    // Stretch by one cycle in T1 signaling frames when allowed
    nxt_st.dw_hold = frame_sync_pulse & t1_mode & signaling_frame
                     & st_ff.io[`B_DW] & st_ff.io[`B_FS_DIR]
                     & ~st_ff.io[`B_FS_MF];
    nxt_st.fs_o = fs_out_raw;

    // Elastic store pointers; commands outrank the slip check and the read tick
    nxt_st.slip = 1'b0;
    if (!st_ff.esc[`B_ES_EN]) begin
      nxt_st.wp = 6'd0;
      nxt_st.rp = 6'd0;
    end else begin
      if (store_wr_tick) begin
        nxt_st.wp = (st_ff.wp + 6'd1) & mask;
      end
      if (rst_edge) begin
        // Minimum delay: read the frame being written, else slip to opposite
        if (rsep <= zone && conversion_mode) begin
          nxt_st.rp   = (base - shift) & mask;
          nxt_st.slip = 1'b1;
        end else begin
          nxt_st.rp = base;
        end
      end else if (align_edge && sep < half) begin
        nxt_st.rp = (st_ff.wp - half) & mask;
      end else if (conversion_mode && sep <= zone) begin
        nxt_st.rp   = (st_ff.rp - shift) & mask;
        nxt_st.slip = 1'b1;
      end else if (store_rd_tick) begin
        nxt_st.rp = (st_ff.rp + 6'd1) & mask;
      end
    end

    // 56k leaves the last bit of each channel empty
    nxt_st.chvalid = ~(st_ff.esc[`B_FMT] & (chan_bit_index == 3'd7));
    nxt_st.chclk   = st_ff.esc[`B_GAP] ? (chan_clk_in & nxt_st.chvalid)
                                       : chan_clk_in;

    if (tx_chan_index == st_ff.mon[4:0]) begin
      nxt_st.mon_byte = tx_chan_byte;
    end

    nxt_st.rx_ser = st_ff.xpc[`B_BERT_DIR] ? bert_data : rx_serial_in;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Pins and polarity
  // ----------------------------------------------------------------
  assign fs_out_raw = frame_sync_pulse | st_ff.dw_hold;
  assign tx_line_clock_level   = st_ff.f_lc ^ st_ff.io[`B_LC_INV];
  assign line_frame_sync_pin_o  = st_ff.fs_o ^ st_ff.io[`B_FS_INV];
  assign line_frame_sync_pin_oe = st_ff.io[`B_FS_DIR];
  assign line_frame_sync_level  = st_ff.f_fs ^ st_ff.io[`B_FS_INV];
  assign tx_sync_multiframe     = st_ff.io[`B_FS_MF];
  // Inversion only on the input path; driven sync leaves as sourced
  assign sys_side_sync_pin_o    = sys_sync_src;
  assign sys_side_sync_pin_oe   = sys_sync_drive;
  assign sys_sync_level = st_ff.f_ss ^ (st_ff.io[`B_SS_INV] & ~sys_sync_drive);
  assign sys_sync_multiframe    = st_ff.io[`B_SS_MF];
  assign sys_clock_rate_select  = st_ff.io[`B_CLK_RATE];
  assign crc_recalc_mode        = st_ff.crc[`B_CRC_RECALC] & ~t1_mode;

  // ----------------------------------------------------------------
  // Datapath steering
  // ----------------------------------------------------------------
  assign channel_clock_out = st_ff.chclk;
  assign channel_bit_valid = st_ff.chvalid;
  assign store_bypass      = ~st_ff.esc[`B_ES_EN];
  assign store_wr_ptr      = st_ff.wp;
  assign store_rd_ptr      = st_ff.rp;
  assign store_slip        = st_ff.slip;

  assign milliwatt_law_select = st_ff.tc4[`B_LAW];
  assign invert_framing   = st_ff.tc4[6:5] == 2'b01;
  assign invert_signaling = st_ff.tc4[6:5] == 2'b10;
  assign invert_payload   = st_ff.tc4[6:5] == 2'b11;

  assign force_bit8 = st_ff.tc4[`B_JAM] & jam_chan_selected;
  assign force_bit7 = st_ff.tc4[`B_JAM] & t1_mode & signaling_frame;

  always_comb begin
    send_rai_ci     = rai_active & t1_mode & esf_mode & st_ff.tc4[`B_RAI];
    send_rai_normal = rai_active & ~send_rai_ci;
    send_ais_ci     = ais_active & t1_mode & st_ff.tc4[`B_AIS];
    send_ais_ones   = ais_active & ~send_ais_ci;
    case (st_ff.tc4[1:0])
      2'b00:   loop_code_bits = 5'd5;
      2'b01:   loop_code_bits = 5'd6;
      2'b10:   loop_code_bits = 5'd7;
      default: loop_code_bits = 5'd16;
    endcase
    case (st_ff.hfc[1:0])
      2'b00:   fifo_low_watermark = 6'd4;
      2'b01:   fifo_low_watermark = 6'd16;
      2'b10:   fifo_low_watermark = 6'd32;
      default: fifo_low_watermark = 6'd48;
    endcase
  end

  assign interleave_active      = st_ff.ibo[`B_IBO_EN];
  assign interleave_select      = st_ff.ibo[`B_IBO_SEL] & st_ff.ibo[`B_IBO_EN];
  assign monitor_channel_select = st_ff.mon[4:0];
  assign rx_serial_data   = st_ff.rx_ser;
  assign bert_to_tx       = st_ff.xpc[`B_BERT_EN] & ~st_ff.xpc[`B_BERT_DIR];
  assign bert_port_enable = st_ff.xpc[`B_BERT_EN];
  assign bert_unframed    = st_ff.xpc[`B_BERT_FUS];

endmodule : t1e1_transmit_path_config

// >>> verif/t1e1_backplane_model.sv
// Backplane model: store write/read strobes and a channel byte stream.
// Assumes one clock shared with the configuration bank.
`timescale 1ns/1ps
module t1e1_backplane_model (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  output logic            store_wr_tick,
  output logic            store_rd_tick,
  output logic            chan_clk_in,
  output logic [2:0]      chan_bit_index,
  output logic [4:0]      tx_chan_index,
  output logic [7:0]      tx_chan_byte
);
  logic [8:0] cnt_ff;
  always_ff @(posedge clk_sys) begin
    if (srst) cnt_ff <= 9'h000;
    else cnt_ff <= cnt_ff + 9'h001;
  end
  // Writes outpace reads so the pointer gap sweeps through the slip zone
  assign store_wr_tick  = cnt_ff[0];
  assign store_rd_tick  = cnt_ff[1:0] == 2'h3;
  assign chan_clk_in    = cnt_ff[0];
  assign chan_bit_index = cnt_ff[3:1];
  assign tx_chan_index  = cnt_ff[8:4];
  // Byte carries its own channel number, so a monitor read names its source
  assign tx_chan_byte   = {3'h5, cnt_ff[8:4]};
endmodule : t1e1_backplane_model

// >>> verif/t1e1_transmit_path_config_monitor.sv
// Port checker for the transmit configuration bank.
// Assumes one clock domain; bound to every instance of the bank.
`timescale 1ns/1ps
module t1e1_transmit_path_config_monitor (
  input wire logic clk_sys, srst, avs_read, avs_write, avs_waitrequest, t1_mode, esf_mode,
  input wire logic conversion_mode, crc_recalc_mode, rai_active, ais_active,
  input wire logic send_rai_normal, send_rai_ci, send_ais_ones, send_ais_ci,
  input wire logic invert_framing, invert_signaling, invert_payload,
  input wire logic jam_chan_selected, force_bit8, bert_to_tx, rx_serial_in, rx_serial_data,
  input wire logic store_bypass, store_slip, interleave_active, interleave_select,
  input wire logic [5:0] store_wr_ptr, store_rd_ptr, fifo_low_watermark,
  input wire logic [4:0] loop_code_bits
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  a_crc_e1_only: assert property (t1_mode |-> !crc_recalc_mode)
    else $error("crc recalc active outside E1");
  a_inv_one_hot: assert property ($onehot0({invert_framing, invert_signaling, invert_payload}))
    else $error("more than one inversion class");
  a_jam_gated: assert property (!jam_chan_selected |-> !force_bit8)
    else $error("bit 8 forced in unselected channel");
  a_rai_normal: assert property (rai_active && !(t1_mode && esf_mode) |-> send_rai_normal && !send_rai_ci)
    else $error("remote alarm variant outside T1 ESF");
  a_ais_normal: assert property (ais_active && !t1_mode |-> send_ais_ones && !send_ais_ci)
    else $error("AIS variant outside T1");
  a_code_len: assert property (loop_code_bits inside {5'h05, 5'h06, 5'h07, 5'h10})
    else $error("loop code length out of set");
  a_wm_level: assert property (fifo_low_watermark inside {6'h04, 6'h10, 6'h20, 6'h30})
    else $error("watermark out of set");
  a_ibo_gated: assert property (!interleave_active |-> !interleave_select)
    else $error("interleave select without enable");
  a_bert_to_tx: assert property (bert_to_tx |=> rx_serial_data == $past(rx_serial_in))
    else $error("receive path not passing serial data");
  a_store_byp: assert property (store_bypass |=> store_wr_ptr == 6'h00 && store_rd_ptr == 6'h00)
    else $error("pointers move while store bypassed");
  a_slip_cause: assert property (store_slip |-> $past(conversion_mode) && !$past(store_bypass))
    else $error("slip outside conversion");
endmodule : t1e1_transmit_path_config_monitor

bind t1e1_transmit_path_config t1e1_transmit_path_config_monitor i_mon (.*);

// >>> verif/t1e1_transmit_path_config_tb_top.sv
// Self-checking bench for the transmit configuration bank.
// Assumes the bank, its map header and the backplane model are compiled first.
`timescale 1ns/1ps
`include "t1e1_tx_cfg_map.svh"
module t1e1_transmit_path_config_tb_top;
  logic clk_sys = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0]  avs_byteenable = 4'hF;
  logic t1_mode = 1'b1, esf_mode = 1'b1, conversion_mode = 1'b0, signaling_frame = 1'b1;
  logic tx_line_clock_in = 1'b0, fs_drv = 1'b0, ss_drv = 1'b0, frame_sync_pulse = 1'b0;
  logic sys_sync_drive = 1'b0, sys_sync_src = 1'b0, jam_chan_selected = 1'b0;
  logic rai_active = 1'b1, ais_active = 1'b1, bert_data = 1'b0, rx_serial_in = 1'b0;
  logic avs_waitrequest, tx_line_clock_level, line_frame_sync_pin_o, line_frame_sync_pin_oe;
  logic line_frame_sync_level, sys_side_sync_pin_o, sys_side_sync_pin_oe, sys_sync_level;
  logic sys_sync_multiframe, tx_sync_multiframe, sys_clock_rate_select, crc_recalc_mode;
  logic chan_clk_in, channel_clock_out, channel_bit_valid, store_wr_tick, store_rd_tick;
  logic store_bypass, store_slip, milliwatt_law_select, invert_framing, invert_signaling;
  logic invert_payload, force_bit8, force_bit7, send_rai_normal, send_rai_ci, send_ais_ones;
  logic send_ais_ci, interleave_active, interleave_select, rx_serial_data, bert_to_tx;
  logic bert_port_enable, bert_unframed, seen;
  logic [1:0]  kk;
  logic [2:0]  chan_bit_index;
  logic [4:0]  loop_code_bits, tx_chan_index, monitor_channel_select;
  logic [5:0]  store_wr_ptr, store_rd_ptr, fifo_low_watermark;
  logic [7:0]  tx_chan_byte, q, d;
  logic [5:0]  lc [4] = '{6'h05, 6'h06, 6'h07, 6'h10};
  logic [5:0]  wm [4] = '{6'h04, 6'h10, 6'h20, 6'h30};
  logic [2:0]  inv [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
  logic [7:0]  esv [3] = '{8'hC0, 8'h80, 8'h40};
  logic [9:0]  idx_l [9] = '{`IDX_IO, `IDX_ESC, `IDX_TC4, `IDX_HFC, `IDX_IBO, `IDX_MON,
                             `IDX_XPC, `IDX_CRC, 10'h190};
  // Wire level of the two-way sync pins from the bank's enable; the bench drives otherwise
  wire line_frame_sync_pin_i = line_frame_sync_pin_oe ? line_frame_sync_pin_o : fs_drv;
  wire sys_side_sync_pin_i   = sys_side_sync_pin_oe ? sys_side_sync_pin_o : ss_drv;
  int mismatches = 0, checks_done = 0, mdl [int];

  t1e1_transmit_path_config i_dut (.*);
  t1e1_backplane_model      i_bp (.*);

  always #10 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", nm, exp_v, seen_v);
    end
  endtask : chk
  function automatic logic [7:0] msk(input logic [9:0] i);
    case (i)
      `IDX_IO, `IDX_TC4: return 8'hFF;
      `IDX_ESC: return `WM_ESC;
      `IDX_HFC: return `WM_HFC;
      `IDX_IBO: return `WM_IBO;
      `IDX_MON: return `WM_MON;
      `IDX_XPC: return `WM_XPC;
      `IDX_CRC: return `WM_CRC;
      default: return `RST_VAL;
    endcase
  endfunction : msk
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] dv,
                     input logic [3:0] be);
    int n;
    n = 0;
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, dv};
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    chk("waitrequest", avs_waitrequest, 1'b0);
    if (wr && be[0]) mdl[idx] = dv & msk(idx);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic read_all();
    foreach (idx_l[i]) begin
      bus(1'b0, idx_l[i], 8'h00, 4'hF);
      chk("register", q, mdl[idx_l[i]]);
    end
  endtask : read_all
  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge clk_sys);
    mismatches++;
    complete_run();
  end
  initial begin
    void'($urandom(7108));
    fork
      forever begin
        @(posedge clk_sys);
        {jam_chan_selected, bert_data, rx_serial_in, frame_sync_pulse, sys_sync_src} <= 5'($urandom);
      end
    join_none
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    foreach (idx_l[i]) mdl[idx_l[i]] = 0;
    read_all();
    repeat (3) begin
      foreach (idx_l[i]) begin
        d = 8'($urandom);
        if (idx_l[i] == `IDX_IO && (d[0] || !d[2])) d[1] = 1'b0;
        bus(1'b1, idx_l[i], d, 4'($urandom));
      end
      read_all();
    end
    bus(1'b1, `IDX_ESC, 8'h00, 4'h1);
    for (int k = 0; k < 4; k++) begin
      kk = 2'(k);
      bus(1'b1, `IDX_TC4, {kk[0], kk, kk[0], kk[0], kk[1], kk}, 4'h1);
      bus(1'b1, `IDX_HFC, {6'h00, kk}, 4'h1);
      bus(1'b1, `IDX_IBO, {3'h0, kk, 3'h0}, 4'h1);
      bus(1'b1, `IDX_XPC, {5'h00, kk, 1'b1}, 4'h1);
      bus(1'b1, `IDX_MON, {3'h0, kk, 3'h7}, 4'h1);
      bus(1'b1, `IDX_IO, {kk[1], kk[1], kk[0], kk[0], kk[1], kk[0], 1'b0, kk[1]}, 4'h1);
      tx_line_clock_in <= 1'b1;
      fs_drv <= 1'b1;
      ss_drv <= 1'b1;
      repeat (600) @(posedge clk_sys);
      chk("loop code bits", loop_code_bits, lc[k]);
      chk("watermark", fifo_low_watermark, wm[k]);
      chk("inversion", {invert_framing, invert_signaling, invert_payload}, inv[k]);
      chk("law", milliwatt_law_select, kk[0]);
      chk("bit8", force_bit8, kk[0] & jam_chan_selected);
      if (jam_chan_selected) chk("bit7", force_bit7, kk[0]);
      chk("rai", {send_rai_ci, send_rai_normal}, {kk[0], ~kk[0]});
      chk("ais", {send_ais_ci, send_ais_ones}, {kk[1], ~kk[1]});
      chk("interleave", {interleave_active, interleave_select}, {kk[0], &kk});
      chk("bert", {bert_port_enable, bert_unframed, bert_to_tx}, {1'b1, kk[0], ~kk[1]});
      chk("monitor select", monitor_channel_select, {kk, 3'h7});
      chk("line clock", tx_line_clock_level, !kk[1]);
      chk("sys sync", sys_sync_level, !kk[0]);
      if (!kk[0]) chk("frame sync", line_frame_sync_level, !kk[1]);
      chk("sync oe", line_frame_sync_pin_oe, kk[0]);
      chk("sync modes", {sys_clock_rate_select, sys_sync_multiframe, tx_sync_multiframe},
          {kk[0], kk[1], kk[1]});
      bus(1'b0, `IDX_MONB, 8'h00, 4'hF);
      chk("monitor byte", q, {3'h5, kk, 3'h7});
    end
    bus(1'b1, `IDX_CRC, 8'h01, 4'h1);
    t1_mode <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("crc recalc", crc_recalc_mode, 1'b1);
    foreach (esv[i]) begin
      bus(1'b1, `IDX_ESC, esv[i], 4'h1);
      // Last bit of a channel with the incoming clock high
      do @(posedge clk_sys); while (!(chan_bit_index == 3'h7 && chan_clk_in));
      @(posedge clk_sys);
      chk("bit valid", channel_bit_valid, !esv[i][7]);
      chk("channel clock", channel_clock_out, !(esv[i][7] && esv[i][6]));
    end
    t1_mode <= 1'b1;
    conversion_mode <= 1'b1;
    bus(1'b1, `IDX_ESC, 8'h01, 4'h1);
    seen = 1'b0;
    for (int n = 0; n < 2000 && !seen; n++) begin
      @(posedge clk_sys);
      seen = store_slip === 1'b1;
    end
    chk("slip", seen, 1'b1);
    // Restart empty without conversion so the gap is small when align lands
    conversion_mode <= 1'b0;
    bus(1'b1, `IDX_ESC, 8'h00, 4'h1);
    bus(1'b1, `IDX_ESC, 8'h01, 4'h1);
    bus(1'b1, `IDX_ESC, 8'h09, 4'h1);
    bus(1'b0, `IDX_STAT, 8'h00, 4'hF);
    chk("align gap", q[5:0] >= 6'd16, 1'b1);
    bus(1'b1, `IDX_ESC, 8'h01, 4'h1);
    bus(1'b1, `IDX_ESC, 8'h05, 4'h1);
    chk("reset frame", store_rd_ptr[4:0], 5'h00);
    bus(1'b1, `IDX_ESC, 8'h00, 4'h1);
    repeat (2) @(posedge clk_sys);
    chk("pointers", {store_wr_ptr, store_rd_ptr, store_bypass}, 13'h0001);
    complete_run();
  end
endmodule : t1e1_transmit_path_config_tb_top
